// ===== common/mpcs_pkg.sv
// Constants, register map and types for the paging and chip-select block.
// Assumes an 8-bit register port and a 16-bit CPU address bus on one clock.
package mpcs_pkg;

  // Register byte addresses on the register port
  localparam logic [7:0] OFS_SEL_DATA   = 8'h30;
  localparam logic [7:0] OFS_EXP_DATA   = 8'h31;
  localparam logic [7:0] OFS_SEL_DIR    = 8'h32;
  localparam logic [7:0] OFS_EXP_DIR    = 8'h33;
  localparam logic [7:0] OFS_DATA_PAGE  = 8'h34;
  localparam logic [7:0] OFS_PROG_PAGE  = 8'h35;
  localparam logic [7:0] OFS_EXTRA_PAGE = 8'h36;
  localparam logic [7:0] OFS_WIN_DEF    = 8'h37;
  localparam logic [7:0] OFS_EXP_ASSIGN = 8'h38;
  localparam logic [7:0] OFS_MISC_CTL   = 8'h39;
  localparam logic [7:0] OFS_SEL_CTL0   = 8'h3C;
  localparam logic [7:0] OFS_SEL_CTL1   = 8'h3D;
  localparam logic [7:0] OFS_STRETCH0   = 8'h3E;
  localparam logic [7:0] OFS_STRETCH1   = 8'h3F;

  // Window definition fields
  localparam int WDEF_DATA_EN  = 7;
  localparam int WDEF_PROG_EN  = 6;
  localparam int WDEF_EXTRA_EN = 5;

  // Misc control fields
  localparam int MISC_PULLUP_EN   = 0;
  localparam int MISC_EXTRA_PLACE = 1;

  // Select control one fields
  localparam int CTL1_P1_FULL_MAP = 6;
  localparam int CTL1_SPLIT_A21   = 5;
  localparam int CTL1_DATA_HALF   = 4;
  localparam int CTL1_P3_FOLLOW_E = 3;

  // Select indices, equal to their enable bit in select control zero
  localparam int CS_0  = 0;
  localparam int CS_1  = 1;
  localparam int CS_2  = 2;
  localparam int CS_3  = 3;
  localparam int CS_D  = 4;
  localparam int CS_P0 = 5;
  localparam int CS_P1 = 6;
  localparam int NUM_CS  = 7;
  localparam int NUM_EXP = 6;

  // Window positions in the CPU map
  localparam logic [3:0] DATA_WIN_TAG = 4'h7;
  localparam logic [1:0] PROG_WIN_TAG = 2'h2;
  localparam logic [1:0] RF_BLOCK_TAG = 2'h1;

  // Reset values
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_SEL_CTL0 = 8'h20;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_STRETCH} mpcs_state_t;

endpackage

// ===== rtl/mpcs_pin_sync.sv
// Three-stage input synchroniser with agreement filter for port pins.
// Assumes pins are asynchronous to clk_sys; output changes when stages two and three agree.
`timescale 1ns/1ps
module mpcs_pin_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_clean
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] mid_r;
  logic [WIDTH-1:0] last_r;
  logic [WIDTH-1:0] clean_r;

  // Stage one feeds only stage two, keeping metastability out of the filter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r  <= '1;
      mid_r   <= '1;
      last_r  <= '1;
      clean_r <= '1;
    end else begin
      meta_r  <= pin_async;
      mid_r   <= meta_r;
      last_r  <= mid_r;
      clean_r <= (mid_r & last_r) | (clean_r & (mid_r ^ last_r));
    end
  end

  assign pin_clean = clean_r;

endmodule

// ===== rtl/mpcs_top.sv
// Memory paging and chip-select unit: address translation, seven selects, stretch, port pins.
// Assumes one CPU access strobe per bus cycle, a register block base from the mode logic, and
// pin buffers outside that resolve out/oe pairs into real pads.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module mpcs_top
  import mpcs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_access,
  input  wire logic        single_chip,
  input  wire logic [4:0]  reg_block_base,
  output logic [15:0]      ext_addr,
  output logic             bus_wait,
  output logic [1:0]       access_stretch,
  input  wire logic [6:0]  sel_pin_in,
  output logic      [6:0]  sel_pin_out,
  output logic      [6:0]  sel_pin_oe,
  output logic      [6:0]  sel_pin_pullup,
  input  wire logic [5:0]  exp_pin_in,
  output logic      [5:0]  exp_pin_out,
  output logic      [5:0]  exp_pin_oe,
  output logic      [5:0]  exp_pin_pullup
);

  typedef struct packed {
    logic [7:0]  sel_data;
    logic [7:0]  exp_data;
    logic [7:0]  sel_dir;
    logic [7:0]  exp_dir;
    logic [7:0]  data_page;
    logic [7:0]  prog_page;
    logic [7:0]  extra_page;
    logic [7:0]  win_def;
    logic [7:0]  exp_assign;
    logic [7:0]  misc_ctl;
    logic [7:0]  sel_ctl0;
    logic [7:0]  sel_ctl1;
    logic [7:0]  stretch0;
    logic [7:0]  stretch1;
    mpcs_state_t st;
    logic [1:0]  cnt;
    logic [21:0] taddr;
    logic [6:0]  cs_n;
    logic [1:0]  stretch;
    logic        wait_f;
    logic [7:0]  rdata;
    logic [6:0]  sel_out;
    logic [6:0]  sel_oe;
    logic [6:0]  sel_pu;
    logic [5:0]  exp_out;
    logic [5:0]  exp_oe;
    logic [5:0]  exp_pu;
  } mpcs_state_reg_t;

  mpcs_state_reg_t s_r;
  mpcs_state_reg_t s_nxt;
  logic [12:0] pin_clean;
  logic        can_take;
  logic        take;
  logic        in_extra;
  logic [21:0] xaddr;
  logic [6:0]  cs_raw;
  logic [6:0]  cs_pick;
  logic [1:0]  pick_stretch;
  // Extra window position follows the placement bit
  function automatic logic extra_hit(input logic [15:0] a, input logic place_low);
    extra_hit = (a[15:11] == 5'h00) && (a[10] == ~place_low);
  endfunction
  // Mixes latch and pin for port reads: outputs read the latch, inputs the pad
  function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] pin);
    port_view = (latch & dir) | (pin & ~dir);
  endfunction
  // Stretch field of one select; fields are two bits, select 0 in the low bits
  function automatic logic [1:0] stretch_of(input logic [6:0] sel, input logic [7:0] st0,
                                            input logic [7:0] st1);
    logic [13:0] all_f;
    all_f = {st0[5:0], st1};
    stretch_of = 2'h0;
    for (int i = 0; i < NUM_CS; i++) begin
      if (sel[i]) begin
        stretch_of = all_f[2*i +: 2];
      end
    end
  endfunction

  mpcs_pin_sync #(
    .WIDTH (13)
  ) u_pin_sync (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .pin_async ({exp_pin_in, sel_pin_in}),
    .pin_clean (pin_clean)
  );

  // Address translation; windows never overlap each other, so order only matters for clarity
  always_comb begin
    in_extra = extra_hit(cpu_addr, s_r.misc_ctl[MISC_EXTRA_PLACE]);
    if (s_r.win_def[WDEF_EXTRA_EN] && in_extra) begin
      xaddr = {4'hF, s_r.extra_page, cpu_addr[9:0]};
    end else if (s_r.win_def[WDEF_PROG_EN] && (cpu_addr[15:14] == PROG_WIN_TAG)) begin
      xaddr = {s_r.prog_page, cpu_addr[13:0]};
    end else if (s_r.win_def[WDEF_DATA_EN] && (cpu_addr[15:12] == DATA_WIN_TAG)) begin
      xaddr = {2'h3, s_r.data_page, cpu_addr[11:0]};
    end else begin
      xaddr = {6'h3F, cpu_addr};
    end
  end

  // Raw select decode, then a strict priority pick so only one can win
  always_comb begin
    logic rf_hit;
    rf_hit = (cpu_addr[15:11] == reg_block_base) && (cpu_addr[10:9] == RF_BLOCK_TAG);
    cs_raw[CS_0] = s_r.sel_ctl0[CS_0] && rf_hit;
    cs_raw[CS_1] = s_r.sel_ctl0[CS_1] && rf_hit && cpu_addr[8];
    cs_raw[CS_2] = s_r.sel_ctl0[CS_2] && rf_hit && (cpu_addr[8:7] == 2'h3);
    cs_raw[CS_3] = s_r.sel_ctl0[CS_3] && (s_r.sel_ctl1[CTL1_P3_FOLLOW_E] ?
                   (s_r.win_def[WDEF_EXTRA_EN] && in_extra) :
                   (rf_hit && (cpu_addr[8:7] == 2'h1)));
    cs_raw[CS_P0] = s_r.sel_ctl0[CS_P0] && cpu_addr[15] &&
                    (!s_r.sel_ctl1[CTL1_SPLIT_A21] || xaddr[21]);
    cs_raw[CS_D] = s_r.sel_ctl0[CS_D] && (s_r.sel_ctl1[CTL1_DATA_HALF] ?
                   !cpu_addr[15] : (cpu_addr[15:12] == DATA_WIN_TAG));
    cs_raw[CS_P1] = s_r.sel_ctl0[CS_P1] && (s_r.sel_ctl1[CTL1_SPLIT_A21] ?
                    (cpu_addr[15] && !xaddr[21]) :
                    (s_r.sel_ctl1[CTL1_P1_FULL_MAP] || cpu_addr[15]));
    // Priority 3, 2, 1, 0, program 0, data, program 1: each bit masked by all above it
    cs_pick[CS_3]  = cs_raw[CS_3];
    cs_pick[CS_2]  = cs_raw[CS_2] && !cs_raw[CS_3];
    cs_pick[CS_1]  = cs_raw[CS_1] && !(|cs_raw[CS_3:CS_2]);
    cs_pick[CS_0]  = cs_raw[CS_0] && !(|cs_raw[CS_3:CS_1]);
    cs_pick[CS_P0] = cs_raw[CS_P0] && !(|cs_raw[CS_3:CS_0]);
    cs_pick[CS_D]  = cs_raw[CS_D] && !(|cs_raw[CS_3:CS_0]) && !cs_raw[CS_P0];
    cs_pick[CS_P1] = cs_raw[CS_P1] && !(|cs_raw[CS_P0:CS_0]);
    pick_stretch = stretch_of(cs_pick, s_r.stretch0, s_r.stretch1);
  end

  // A new access is accepted only when no stretch is pending
  assign can_take = (s_r.st == ST_IDLE) || ((s_r.st == ST_ACCESS) && (s_r.cnt == 2'h0));
  assign take     = cpu_access && can_take;

  // Next state: registers, bus-cycle sequencer and pin drivers
  always_comb begin
    s_nxt       = s_r;
    s_nxt.rdata = 8'h00;
    // Register writes land at the edge, so the next access already sees them
    if (reg_wr) begin
      case (reg_addr)
        OFS_SEL_DATA:   s_nxt.sel_data   = reg_wdata;
        OFS_EXP_DATA:   s_nxt.exp_data   = reg_wdata;
        OFS_SEL_DIR:    s_nxt.sel_dir    = reg_wdata;
        OFS_EXP_DIR:    s_nxt.exp_dir    = reg_wdata;
        OFS_DATA_PAGE:  s_nxt.data_page  = reg_wdata;
        OFS_PROG_PAGE:  s_nxt.prog_page  = reg_wdata;
        OFS_EXTRA_PAGE: s_nxt.extra_page = reg_wdata;
        OFS_WIN_DEF:    s_nxt.win_def    = reg_wdata & 8'hE0;
        OFS_EXP_ASSIGN: s_nxt.exp_assign = reg_wdata & 8'h3F;
        OFS_MISC_CTL:   s_nxt.misc_ctl   = reg_wdata & 8'h03;
        OFS_SEL_CTL0:   s_nxt.sel_ctl0   = reg_wdata & 8'h7F;
        OFS_SEL_CTL1:   s_nxt.sel_ctl1   = reg_wdata & 8'h78;
        OFS_STRETCH0:   s_nxt.stretch0   = reg_wdata & 8'h3F;
        OFS_STRETCH1:   s_nxt.stretch1   = reg_wdata;
        default:        s_nxt.rdata      = 8'h00;
      endcase
    end
    // Read data stands for exactly the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        OFS_SEL_DATA:   s_nxt.rdata = port_view(s_r.sel_data, s_r.sel_dir, {1'b0, pin_clean[6:0]});
        OFS_EXP_DATA:   s_nxt.rdata = port_view(s_r.exp_data, s_r.exp_dir, {2'h0, pin_clean[12:7]});
        OFS_SEL_DIR:    s_nxt.rdata = s_r.sel_dir;
        OFS_EXP_DIR:    s_nxt.rdata = s_r.exp_dir;
        OFS_DATA_PAGE:  s_nxt.rdata = s_r.data_page;
        OFS_PROG_PAGE:  s_nxt.rdata = s_r.prog_page;
        OFS_EXTRA_PAGE: s_nxt.rdata = s_r.extra_page;
        OFS_WIN_DEF:    s_nxt.rdata = s_r.win_def;
        OFS_EXP_ASSIGN: s_nxt.rdata = s_r.exp_assign;
        OFS_MISC_CTL:   s_nxt.rdata = s_r.misc_ctl;
        OFS_SEL_CTL0:   s_nxt.rdata = s_r.sel_ctl0;
        OFS_SEL_CTL1:   s_nxt.rdata = s_r.sel_ctl1;
        OFS_STRETCH0:   s_nxt.rdata = s_r.stretch0;
        OFS_STRETCH1:   s_nxt.rdata = s_r.stretch1;
        default:        s_nxt.rdata = 8'h00;
      endcase
    end
    // Bus cycle: one access cycle, then as many stretch cycles as the winning select asks
    case (s_r.st)
      ST_IDLE: begin
        if (take) begin
          s_nxt.st = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (s_r.cnt != 2'h0) begin
          s_nxt.st     = ST_STRETCH;
          s_nxt.wait_f = 1'b1;
        end else if (!take) begin
          s_nxt.st   = ST_IDLE;
          s_nxt.cs_n = 7'h7F;
        end
      end
      ST_STRETCH: begin
        s_nxt.cnt = s_r.cnt - 2'h1;
        if (s_r.cnt == 2'h1) begin
          s_nxt.st     = ST_IDLE;
          s_nxt.wait_f = 1'b0;
          s_nxt.cs_n   = 7'h7F;
        end
      end
      default: begin
        s_nxt.st     = ST_IDLE;
        s_nxt.cnt    = 2'h0;
        s_nxt.wait_f = 1'b0;
        s_nxt.cs_n   = 7'h7F;
      end
    endcase
    if (take) begin
      s_nxt.taddr   = xaddr;
      s_nxt.cs_n    = ~cs_pick;
      s_nxt.stretch = pick_stretch;
      s_nxt.cnt     = pick_stretch;
    end
    // Select port: an enabled select owns its pin unless the part runs single-chip
    for (int i = 0; i < NUM_CS; i++) begin
      if (s_nxt.sel_ctl0[i] && !single_chip) begin
        s_nxt.sel_out[i] = s_nxt.cs_n[i];
        s_nxt.sel_oe[i]  = 1'b1;
      end else begin
        s_nxt.sel_out[i] = s_nxt.sel_data[i];
        s_nxt.sel_oe[i]  = s_nxt.sel_dir[i];
      end
    end
    // Expansion port: assigned pins carry the translated upper address
    for (int i = 0; i < NUM_EXP; i++) begin
      if (s_nxt.exp_assign[i] && !single_chip) begin
        s_nxt.exp_out[i] = s_nxt.taddr[16+i];
        s_nxt.exp_oe[i]  = 1'b1;
      end else begin
        s_nxt.exp_out[i] = s_nxt.exp_data[i];
        s_nxt.exp_oe[i]  = s_nxt.exp_dir[i];
      end
    end
    // Pull-ups only on pins that are not driven
    s_nxt.sel_pu = {7{s_nxt.misc_ctl[MISC_PULLUP_EN]}} & ~s_nxt.sel_oe;
    s_nxt.exp_pu = {6{s_nxt.misc_ctl[MISC_PULLUP_EN]}} & ~s_nxt.exp_oe;
  end

  // State register; program select zero comes up enabled so the boot fetch works
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_r          <= '0;
      s_r.sel_ctl0 <= RST_SEL_CTL0;
      s_r.st       <= ST_IDLE;
      s_r.cs_n     <= 7'h7F;
      s_r.taddr    <= 22'h3FFFFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata      = s_r.rdata;
  assign ext_addr       = s_r.taddr[15:0];
  assign bus_wait       = s_r.wait_f;
  assign access_stretch = s_r.stretch;
  assign sel_pin_out    = s_r.sel_out;
  assign sel_pin_oe     = s_r.sel_oe;
  assign sel_pin_pullup = s_r.sel_pu;
  assign exp_pin_out    = s_r.exp_out;
  assign exp_pin_oe     = s_r.exp_oe;
  assign exp_pin_pullup = s_r.exp_pu;

  // Checks on the translated address, the selects and the pins
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_take_stretch3;
    take && (pick_stretch == 2'h3);
  endsequence
  sequence s_three_waits;
    !bus_wait ##1 bus_wait [*3] ##1 !bus_wait;
  endsequence
  property p_data_page;
    take && s_r.win_def[WDEF_DATA_EN] && (cpu_addr[15:12] == 4'h7)
      |=> (ext_addr[15:12] == $past(s_r.data_page[3:0])) && (s_r.taddr[21:16] == {2'h3, $past(s_r.data_page[7:4])});
  endproperty
  a_data_page: assert property (p_data_page) else $error("data page not translated");
  property p_prog_page;
    take && s_r.win_def[WDEF_PROG_EN] && (cpu_addr[15:14] == 2'h2)
      |=> s_r.taddr[21:14] == $past(s_r.prog_page);
  endproperty
  a_prog_page: assert property (p_prog_page) else $error("program page not translated");
  property p_extra_page;
    take && s_r.win_def[WDEF_EXTRA_EN] && in_extra
      |=> s_r.taddr[21:10] == {4'hF, $past(s_r.extra_page)};
  endproperty
  a_extra_page: assert property (p_extra_page) else $error("extra page not translated");
  property p_no_window;
    take && (s_r.win_def == 8'h00) |=> s_r.taddr == {6'h3F, $past(cpu_addr)};
  endproperty
  a_no_window: assert property (p_no_window) else $error("address altered with windows off");
  property p_one_select;
    $countones(~s_r.cs_n) <= 1;
  endproperty
  a_one_select: assert property (p_one_select) else $error("two selects active");
  property p_cs2_top;
    take && (s_r.sel_ctl0[3:0] == 4'hF) && !s_r.sel_ctl1[CTL1_P3_FOLLOW_E] &&
      (cpu_addr[15:11] == reg_block_base) && (cpu_addr[10:7] == 4'h7)
      |=> (s_r.cs_n[3:0] == 4'hB);
  endproperty
  a_cs2_top: assert property (p_cs2_top) else $error("select 2 lost its top block");
  property p_stretch3;
    s_take_stretch3 |-> ##1 s_three_waits;
  endproperty
  a_stretch3: assert property (p_stretch3) else $error("stretch of three not honoured");
  property p_single_chip_pins;
    single_chip |=> (sel_pin_oe == $past(s_nxt.sel_dir[6:0])) && (exp_pin_oe == $past(s_nxt.exp_dir[5:0]));
  endproperty
  a_single_chip_pins: assert property (p_single_chip_pins) else $error("pins claimed in single-chip");
  property p_assign_drives;
    !single_chip |=> ((exp_pin_oe & $past(s_nxt.exp_assign[5:0])) == $past(s_nxt.exp_assign[5:0]));
  endproperty
  a_assign_drives: assert property (p_assign_drives) else $error("assigned pin not driven");
  property p_pullup;
    sel_pin_pullup == ({7{s_r.misc_ctl[MISC_PULLUP_EN]}} & ~sel_pin_oe);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");

endmodule

// ===== verif/mpcs_ext_mem.sv
// Far-side model: external memories and peripherals on the select and expansion pads.
// Assumes out/oe/pullup triples from the block; resolves each pad and feeds it back.
`timescale 1ns/1ps
module mpcs_ext_mem (
  input  wire logic        clk_sys,
  input  wire logic [6:0]  sel_out,
  input  wire logic [6:0]  sel_oe,
  input  wire logic [6:0]  sel_pu,
  input  wire logic [5:0]  exp_out,
  input  wire logic [5:0]  exp_oe,
  input  wire logic [5:0]  exp_pu,
  output logic      [6:0]  sel_pad,
  output logic      [5:0]  exp_pad,
  output logic      [15:0] multi_hits
);
  logic flip_r = 1'b0;

  // Floating pads wander every cycle so a stale level never passes as driven
  always @(posedge clk_sys) flip_r <= ~flip_r;

  // Pad level: block driver first, then pull-up, else wandering
  always_comb begin
    for (int i = 0; i < 7; i++) sel_pad[i] = sel_oe[i] ? sel_out[i] : (sel_pu[i] | flip_r);
    for (int i = 0; i < 6; i++) exp_pad[i] = exp_oe[i] ? exp_out[i] : (exp_pu[i] | flip_r);
  end

  // Two devices selected at once would fight on the data bus
  initial multi_hits = 16'h0000;
  always @(posedge clk_sys) begin
    if ($countones(~sel_pad & sel_oe) > 1) multi_hits <= multi_hits + 16'h0001;
  end
endmodule

// ===== verif/mpcs_top_test.sv
// Self-checking bench for the paging and chip-select unit.
// Assumes the register block sits at 0x0800, so the following selects live at 0x0A00-0x0BFF.
`timescale 1ns/1ps
module mpcs_top_test import mpcs_pkg::*;;
  typedef struct {logic [15:0] a; logic [15:0] ea; logic [5:0] ex; int idx; int n;} mpcs_row_t;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, cpu_access, single_chip, bus_wait;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [15:0] cpu_addr, ext_addr, multi_hits;
  logic [4:0]  reg_block_base;
  logic [1:0]  access_stretch;
  logic [6:0]  sel_pin_in, sel_pin_out, sel_pin_oe, sel_pin_pullup;
  logic [5:0]  exp_pin_in, exp_pin_out, exp_pin_oe, exp_pin_pullup;
  int          bad_count, samples_checked, cycles;
  // Config: pages, all windows, all pins assigned, all selects, data half + follow extra
  logic [7:0]  ofs[9] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h3C, 8'h3D, 8'h3E, 8'h3F};
  logic [7:0]  val[9] = '{8'hA5, 8'h96, 8'h3C, 8'hE0, 8'h3F, 8'h7F, 8'h18, 8'h1B, 8'hE4};
  // Address, translated address, expansion pins, winning select, stretch
  mpcs_row_t   rows[8] = '{'{16'h7123, 16'h5123, 6'h3A, CS_D, 3}, '{16'h8456, 16'h8456, 6'h25, CS_P0, 2},
    '{16'hC010, 16'hC010, 6'h3F, CS_P0, 2}, '{16'h0512, 16'hF112, 6'h3C, CS_3, 3},
    '{16'h0A10, 16'h0A10, 6'h3F, CS_0, 0}, '{16'h0B10, 16'h0B10, 6'h3F, CS_1, 1},
    '{16'h0B90, 16'h0B90, 6'h3F, CS_2, 2}, '{16'h2000, 16'h2000, 6'h3F, CS_D, 3}};

  mpcs_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_access(cpu_access),
    .single_chip(single_chip), .reg_block_base(reg_block_base), .ext_addr(ext_addr), .bus_wait(bus_wait),
    .access_stretch(access_stretch), .sel_pin_in(sel_pin_in), .sel_pin_out(sel_pin_out), .sel_pin_oe(sel_pin_oe),
    .sel_pin_pullup(sel_pin_pullup), .exp_pin_in(exp_pin_in), .exp_pin_out(exp_pin_out), .exp_pin_oe(exp_pin_oe),
    .exp_pin_pullup(exp_pin_pullup));
  mpcs_ext_mem mem_u (.clk_sys(clk_sys), .sel_out(sel_pin_out), .sel_oe(sel_pin_oe), .sel_pu(sel_pin_pullup),
    .exp_out(exp_pin_out), .exp_oe(exp_pin_oe), .exp_pu(exp_pin_pullup), .sel_pad(sel_pin_in),
    .exp_pad(exp_pin_in), .multi_hits(multi_hits));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    $display("counts: %0d checked, %0d unexpected", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask

  // One bus access; six cycles cover the longest stretch plus the release
  task automatic acc(input logic [15:0] a, input logic [15:0] ea, input logic [5:0] ex, input int idx, input int n);
    int waits;
    int lows;
    waits = 0;
    lows = 0;
    @(posedge clk_sys);
    cpu_access <= 1'b1;
    cpu_addr <= a;
    @(posedge clk_sys);
    cpu_access <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk_sys);
      if (i == 0) begin
        chk("ext_addr", ea, ext_addr);
        chk("exp_pin_out", 16'(ex), 16'(exp_pin_out));
        chk("sel_pin_out", {9'h000, ~(7'h01 << idx)}, 16'(sel_pin_out));
        chk("access_stretch", 16'(n), 16'(access_stretch));
      end
      if (bus_wait === 1'b1) waits++;
      if (sel_pin_out !== 7'h7F) lows++;
    end
    chk("bus_wait cycles", 16'(n), 16'(waits));
    chk("select low cycles", (idx < 7) ? 16'(n + 1) : 16'h0000, 16'(lows));
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      $display("unexpected run length: expected under 4000 cycles, seen 4000");
      give_verdict();
    end
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, cpu_access, single_chip} = 5'b10000;
    {reg_addr, reg_wdata, cpu_addr} = 32'h0000_0000;
    reg_block_base = 5'h01;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i], d);
      chk("reset value", 16'((ofs[i] == OFS_SEL_CTL0) ? RST_SEL_CTL0 : RST_ZERO), 16'(d));
    end
    chk("sel_pin_oe after reset", 16'h0020, 16'(sel_pin_oe));
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      wr(ofs[i], val[i]);
      rd(ofs[i], d);
      chk("register readback", 16'(val[i]), 16'(d));
    end
    wr(8'h3A, 8'hFF);
    rd(8'h3A, d);
    chk("unmapped read", 16'h0000, 16'(d));
    $display("test register access done");
    foreach (rows[i]) acc(rows[i].a, rows[i].ea, rows[i].ex, rows[i].idx, rows[i].n);
    // Placement bit set: extra window moves down to 0x0000, 0x0400 becomes plain data space
    wr(8'h39, 8'h02);
    acc(16'h0112, 16'hF112, 6'h3C, CS_3, 3);
    acc(16'h0512, 16'h0512, 6'h3F, CS_D, 3);
    $display("test decode table done");
    // Back-to-back writes, then an access right after them
    wr(8'h3D, 8'h00);
    wr(8'h37, 8'h00);
    acc(16'h7123, 16'h7123, 6'h3F, CS_D, 3);
    acc(16'h0A90, 16'h0A90, 6'h3F, CS_3, 3);
    acc(16'h2000, 16'h2000, 6'h3F, 7, 0);
    wr(8'h3D, 8'h40);
    acc(16'h2000, 16'h2000, 6'h3F, CS_P1, 1);
    wr(8'h3D, 8'h20);
    wr(8'h37, 8'h40);
    acc(16'h8456, 16'h8456, 6'h25, CS_P0, 2);
    wr(8'h35, 8'h16);
    acc(16'h8456, 16'h8456, 6'h05, CS_P1, 1);
    acc(16'hC010, 16'hC010, 6'h3F, CS_P0, 2);
    $display("test window and select options done");
    // Single-chip mode: both ports fall back to plain I/O
    @(posedge clk_sys);
    single_chip <= 1'b1;
    wr(8'h33, 8'h0F);
    wr(8'h31, 8'h05);
    wr(8'h39, 8'h01);
    wr(8'h32, 8'h00);
    repeat (6) @(negedge clk_sys);
    chk("exp_pin_oe", 16'h000F, 16'(exp_pin_oe));
    chk("exp_pin_out low bits", 16'h0005, 16'(exp_pin_out & 6'h0F));
    chk("exp_pin_pullup", 16'h0030, 16'(exp_pin_pullup));
    chk("sel_pin_oe", 16'h0000, 16'(sel_pin_oe));
    chk("sel_pin_pullup", 16'h007F, 16'(sel_pin_pullup));
    rd(8'h31, d);
    chk("exp port read", 16'h0035, 16'(d & 8'h3F));
    @(posedge clk_sys);
    single_chip <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("sel_pin_oe", 16'h007F, 16'(sel_pin_oe));
    chk("exp_pin_oe", 16'h003F, 16'(exp_pin_oe));
    chk("exp_pin_pullup", 16'h0000, 16'(exp_pin_pullup));
    chk("double selects", 16'h0000, multi_hits);
    $display("test port pins done");
    give_verdict();
  end
endmodule
